// File: hdl/sdm_monitor.sv
// Serial debug monitor: strap decode, command parser and memory access sequencer.
// Assumes the processor side acknowledges each memory request with a one-cycle ack.
// Contract
// - Debug straps start processor in monitor ROM
// - Debug mode: pull-down inputs, port 3 serial
// - Strap selects 31250 or 57600 baud
// - Debug protocol uses only serial pin pair
// - Every command answered or acked, except jump/resume and block read with zero count
// - Link-establish F0 answered with acknowledge
// - Internal RAM read/write, word low first
// - Memory word read, four address bytes
// - Memory write; flash programmed; ack after completion
// - I/O word read and write
// - DSP RAM low or high half read
// - DSP RAM 32-bit write then ack
// - Jump to address, or resume saved context
// - Block read returns twice count bytes
module sdm_monitor
	import sdm_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clkEn,
	// Mode straps
	input wire logic modeStrapA,
	input wire logic modeStrapB,
	input wire logic baudSelectStrap,
	// Serial pair
	input wire logic serialReceivePin,
	output logic serialTransmitPin,
	// Boot and port setup
	output logic monitorBoot,
	output logic serialPinsSelected,
	output logic [63:0] portPullDown,
	// Memory access
	output sdm_mem_req_t memReq,
	input wire sdm_mem_rsp_t memRsp,
	// Firmware control
	output sdm_exec_t execCtl
);
	logic debugMode_r, debugMode_nxt;
	logic fastBaud_r, fastBaud_nxt;
	logic [63:0] pullDown_r, pullDown_nxt;
	logic [15:0] bitDiv;
	logic rxValid;
	logic [7:0] rxByte;
	logic txBusy;
	logic txDone;
	logic txLine;

	sdm_state_t state_r, state_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic [7:0] params_r [SDM_MAX_PARAMS];
	logic [7:0] params_nxt [SDM_MAX_PARAMS];
	logic [2:0] pCnt_r, pCnt_nxt;
	logic [2:0] pNeed;
	logic cmdKnown;
	logic [31:0] addr_r, addr_nxt;
	logic [15:0] words_r, words_nxt;
	logic [15:0] data_r, data_nxt;
	logic hiPending_r, hiPending_nxt;
	logic txGo_r, txGo_nxt;
	logic [7:0] txByte_r, txByte_nxt;
	sdm_mem_req_t req_r, req_nxt;
	sdm_exec_t exec_r, exec_nxt;
	logic [31:0] memAddr;

	////////////////////////////////////////////////////////////////////////
	// Strap capture at reset; straps are read only while srst is held
	always_comb begin
		debugMode_nxt = debugMode_r;
		fastBaud_nxt = fastBaud_r;
		pullDown_nxt = pullDown_r;
		if (srst) begin
			debugMode_nxt = modeStrapA && !modeStrapB;
			fastBaud_nxt = baudSelectStrap;
			pullDown_nxt = (modeStrapA && !modeStrapB) ? SDM_PULL_DOWN_MASK : '1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst || clkEn) begin
			debugMode_r <= debugMode_nxt;
			fastBaud_r <= fastBaud_nxt;
			pullDown_r <= pullDown_nxt;
		end
	end

	assign bitDiv = fastBaud_r ? SDM_DIV_FAST : SDM_DIV_STD;

	////////////////////////////////////////////////////////////////////////
	// Serial pair is the only path for the protocol
	sdm_uart_rx uRx (
		.ref_clk(ref_clk),
		.srst(srst),
		.clkEn(clkEn),
		.rxLine(serialReceivePin),
		.bitDiv(bitDiv),
		.rxValid(rxValid),
		.rxByte(rxByte)
	);

	sdm_uart_tx uTx (
		.ref_clk(ref_clk),
		.srst(srst),
		.clkEn(clkEn),
		.bitDiv(bitDiv),
		.txGo(txGo_r),
		.txByte(txByte_r),
		.txBusy(txBusy),
		.txDone(txDone),
		.txLine(txLine)
	);

	////////////////////////////////////////////////////////////////////////
	// Parameter byte count per command; unknown codes are dropped silently
	always_comb begin
		cmdKnown = 1'b1;
		case (cmd_r)
			SDM_CMD_LINK_INIT: pNeed = 3'd0;
			SDM_CMD_PROCESSOR_INTERNAL_RAM_RD: pNeed = 3'd1;
			SDM_CMD_PROCESSOR_INTERNAL_RAM_WR: pNeed = 3'd3;
			SDM_CMD_MEM_RD: pNeed = 3'd4;
			SDM_CMD_MEM_WR: pNeed = 3'd6;
			SDM_CMD_IO_RD: pNeed = 3'd1;
			SDM_CMD_IO_WR: pNeed = 3'd3;
			SDM_CMD_DSP_LO_RD: pNeed = 3'd2;
			SDM_CMD_DSP_HI_RD: pNeed = 3'd2;
			SDM_CMD_DSP_WR: pNeed = 3'd6;
			SDM_CMD_JUMP: pNeed = 3'd2;
			SDM_CMD_RESUME: pNeed = 3'd1;
			SDM_CMD_BLOCK_RD: pNeed = 3'd6;
			default: begin
				pNeed = 3'd0;
				cmdKnown = 1'b0;
			end
		endcase
	end

	assign memAddr = {params_r[3], params_r[2], params_r[1], params_r[0]};

	////////////////////////////////////////////////////////////////////////
	// Command sequencer
	always_comb begin
		state_nxt = state_r;
		cmd_nxt = cmd_r;
		params_nxt = params_r;
		pCnt_nxt = pCnt_r;
		addr_nxt = addr_r;
		words_nxt = words_r;
		data_nxt = data_r;
		hiPending_nxt = hiPending_r;
		txGo_nxt = 1'b0;
		txByte_nxt = txByte_r;
		req_nxt = req_r;
		exec_nxt = exec_r;
		exec_nxt.jump = 1'b0;
		exec_nxt.resume = 1'b0;
		case (state_r)
			SDM_S_IDLE: begin
				// Bytes arriving mid-answer are ignored; host must wait
				if (rxValid && debugMode_r) begin
					cmd_nxt = rxByte;
					pCnt_nxt = 3'd0;
					state_nxt = SDM_S_PARAM;
				end
			end
			SDM_S_PARAM: begin
				if (!cmdKnown)
					state_nxt = SDM_S_IDLE;
				else if (pCnt_r == pNeed)
					state_nxt = SDM_S_EXEC;
				else if (rxValid) begin
					params_nxt[pCnt_r] = rxByte;
					pCnt_nxt = pCnt_r + 3'd1;
				end
			end
			SDM_S_EXEC: begin
				req_nxt.valid = 1'b1;
				req_nxt.write = 1'b0;
				req_nxt.flash = 1'b0;
				req_nxt.wdata = '0;
				state_nxt = SDM_S_WAIT;
				hiPending_nxt = 1'b0;
				case (cmd_r)
					SDM_CMD_LINK_INIT: begin
						req_nxt.valid = 1'b0;
						txByte_nxt = SDM_ACK_BYTE;
						state_nxt = SDM_S_SEND;
					end
					SDM_CMD_PROCESSOR_INTERNAL_RAM_RD, SDM_CMD_PROCESSOR_INTERNAL_RAM_WR: begin
						req_nxt.space = SDM_SP_PROCESSOR_INTERNAL_RAM;
						req_nxt.addr = {24'h000000, params_r[0]};
						req_nxt.write = (cmd_r == SDM_CMD_PROCESSOR_INTERNAL_RAM_WR);
						req_nxt.wdata = {16'h0000, params_r[2], params_r[1]};
					end
					SDM_CMD_MEM_RD: begin
						req_nxt.space = SDM_SP_MEM;
						req_nxt.addr = memAddr;
						words_nxt = 16'h0001;
					end
					SDM_CMD_MEM_WR: begin
						req_nxt.space = SDM_SP_MEM;
						req_nxt.addr = memAddr;
						req_nxt.write = 1'b1;
						req_nxt.flash = (memAddr >= SDM_FLASH_LO) && (memAddr <= SDM_FLASH_HI);
						req_nxt.wdata = {16'h0000, params_r[5], params_r[4]};
					end
					SDM_CMD_IO_RD, SDM_CMD_IO_WR: begin
						req_nxt.space = SDM_SP_IO;
						req_nxt.addr = {24'h000000, params_r[0]};
						req_nxt.write = (cmd_r == SDM_CMD_IO_WR);
						req_nxt.wdata = {16'h0000, params_r[2], params_r[1]};
					end
					SDM_CMD_DSP_LO_RD, SDM_CMD_DSP_HI_RD, SDM_CMD_DSP_WR: begin
						req_nxt.space = SDM_SP_DSP;
						req_nxt.addr = {16'h0000, params_r[1], params_r[0]};
						req_nxt.write = (cmd_r == SDM_CMD_DSP_WR);
						req_nxt.wdata = {params_r[5], params_r[4], params_r[3], params_r[2]};
					end
					SDM_CMD_JUMP: begin
						req_nxt.valid = 1'b0;
						exec_nxt.jump = 1'b1;
						exec_nxt.addr = {params_r[1], params_r[0]};
						state_nxt = SDM_S_IDLE;
					end
					SDM_CMD_RESUME: begin
						req_nxt.valid = 1'b0;
						exec_nxt.resume = 1'b1;
						state_nxt = SDM_S_IDLE;
					end
					default: begin
						// Block read; zero count answers nothing
						req_nxt.space = SDM_SP_MEM;
						req_nxt.addr = memAddr;
						words_nxt = {params_r[5], params_r[4]};
						addr_nxt = memAddr;
						if ({params_r[5], params_r[4]} == 16'h0000) begin
							req_nxt.valid = 1'b0;
							state_nxt = SDM_S_IDLE;
						end
					end
				endcase
			end
			SDM_S_WAIT: begin
				// Flash writes hold here until the programming sequence ends
				if (memRsp.ack) begin
					req_nxt.valid = 1'b0;
					state_nxt = SDM_S_SEND;
					if (req_r.write) begin
						txByte_nxt = SDM_ACK_BYTE;
					end else begin
						data_nxt = (cmd_r == SDM_CMD_DSP_HI_RD) ? memRsp.rdata[31:16] : memRsp.rdata[15:0];
						txByte_nxt = (cmd_r == SDM_CMD_DSP_HI_RD) ? memRsp.rdata[23:16] : memRsp.rdata[7:0];
						hiPending_nxt = 1'b1;
					end
				end
			end
			SDM_S_SEND: begin
				if (!txBusy) begin
					txGo_nxt = 1'b1;
					state_nxt = SDM_S_DRAIN;
				end
			end
			SDM_S_DRAIN: begin
				// Next byte only after stop bit has gone out
				if (txDone) begin
					if (hiPending_r) begin
						hiPending_nxt = 1'b0;
						txByte_nxt = data_r[15:8];
						state_nxt = SDM_S_SEND;
					end else if (cmd_r == SDM_CMD_BLOCK_RD && words_r > 16'h0001) begin
						words_nxt = words_r - 16'h0001;
						addr_nxt = addr_r + 32'h0000_0001;
						req_nxt.valid = 1'b1;
						req_nxt.addr = addr_r + 32'h0000_0001;
						state_nxt = SDM_S_WAIT;
					end else begin
						state_nxt = SDM_S_IDLE;
					end
				end
			end
			default: state_nxt = SDM_S_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_r <= SDM_S_IDLE;
			cmd_r <= 8'h00;
			for (int i = 0; i < SDM_MAX_PARAMS; i++)
				params_r[i] <= 8'h00;
			pCnt_r <= 3'd0;
			addr_r <= 32'h0000_0000;
			words_r <= 16'h0000;
			data_r <= 16'h0000;
			hiPending_r <= 1'b0;
			txGo_r <= 1'b0;
			txByte_r <= 8'h00;
			req_r <= '0;
			exec_r <= '0;
		end else if (clkEn) begin
			state_r <= state_nxt;
			cmd_r <= cmd_nxt;
			params_r <= params_nxt;
			pCnt_r <= pCnt_nxt;
			addr_r <= addr_nxt;
			words_r <= words_nxt;
			data_r <= data_nxt;
			hiPending_r <= hiPending_nxt;
			txGo_r <= txGo_nxt;
			txByte_r <= txByte_nxt;
			req_r <= req_nxt;
			exec_r <= exec_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all from flops
	assign serialTransmitPin = txLine;
	assign monitorBoot = debugMode_r;
	assign serialPinsSelected = debugMode_r;
	assign portPullDown = pullDown_r;
	assign memReq = req_r;
	assign execCtl = exec_r;
endmodule : sdm_monitor

// File: hdl/sdm_pkg.sv
// Package for the serial debug monitor: codes, constants, carrier types.
// Assumes a single 40 MHz clock domain shared by every design file.
package sdm_pkg;
	// Clock and bit timing
	localparam int unsigned SDM_CLK_HZ = 40000000;
	localparam int unsigned SDM_BAUD_STD = 31250;
	localparam int unsigned SDM_BAUD_FAST = 57600;
	localparam logic [15:0] SDM_DIV_STD = 16'(SDM_CLK_HZ / SDM_BAUD_STD);
	localparam logic [15:0] SDM_DIV_FAST = 16'(SDM_CLK_HZ / SDM_BAUD_FAST);
	localparam int unsigned SDM_DATA_BITS = 8;

	// Command codes
	localparam logic [7:0] SDM_CMD_LINK_INIT = 8'hF0;
	localparam logic [7:0] SDM_CMD_PROCESSOR_INTERNAL_RAM_RD = 8'h00;
	localparam logic [7:0] SDM_CMD_PROCESSOR_INTERNAL_RAM_WR = 8'h01;
	localparam logic [7:0] SDM_CMD_MEM_RD = 8'h02;
	localparam logic [7:0] SDM_CMD_MEM_WR = 8'h03;
	localparam logic [7:0] SDM_CMD_IO_RD = 8'h04;
	localparam logic [7:0] SDM_CMD_IO_WR = 8'h05;
	localparam logic [7:0] SDM_CMD_DSP_LO_RD = 8'h06;
	localparam logic [7:0] SDM_CMD_DSP_HI_RD = 8'h07;
	localparam logic [7:0] SDM_CMD_DSP_WR = 8'h08;
	localparam logic [7:0] SDM_CMD_JUMP = 8'h09;
	localparam logic [7:0] SDM_CMD_RESUME = 8'h0A;
	localparam logic [7:0] SDM_CMD_BLOCK_RD = 8'h0B;
	localparam logic [7:0] SDM_ACK_BYTE = 8'hAC;

	// Built-in flash window in the memory space
	localparam logic [31:0] SDM_FLASH_LO = 32'h0000_8000;
	localparam logic [31:0] SDM_FLASH_HI = 32'h0000_DFFF;

	// Port layout: 4 ports of 16 bits, serial pair on port 3 bits 10 and 11
	localparam int unsigned SDM_PORT_BITS = 64;
	localparam int unsigned SDM_RX_PORT_BIT = 58;
	localparam int unsigned SDM_TX_PORT_BIT = 59;
	localparam logic [63:0] SDM_PULL_DOWN_MASK = 64'hF3FF_FFFF_FFFF_FFFF;

	localparam int unsigned SDM_MAX_PARAMS = 6;

	typedef enum logic [2:0] {
		SDM_SP_PROCESSOR_INTERNAL_RAM = 3'h0,
		SDM_SP_MEM = 3'h1,
		SDM_SP_IO = 3'h2,
		SDM_SP_DSP = 3'h3
	} sdm_space_t;

	typedef enum logic [2:0] {
		SDM_S_IDLE = 3'h0,
		SDM_S_PARAM = 3'h1,
		SDM_S_EXEC = 3'h2,
		SDM_S_WAIT = 3'h3,
		SDM_S_SEND = 3'h4,
		SDM_S_DRAIN = 3'h5
	} sdm_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic flash;
		sdm_space_t space;
		logic [31:0] addr;
		logic [31:0] wdata;
	} sdm_mem_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} sdm_mem_rsp_t;

	typedef struct packed {
		logic jump;
		logic resume;
		logic [15:0] addr;
	} sdm_exec_t;
endpackage : sdm_pkg

// File: hdl/sdm_uart_rx.sv
// Serial byte receiver, 8N1, bit period set by a divisor input.
// Assumes the line input is already synchronous to ref_clk.
module sdm_uart_rx
	import sdm_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clkEn,
	// Line and timing
	input wire logic rxLine,
	input wire logic [15:0] bitDiv,
	// Received byte
	output logic rxValid,
	output logic [7:0] rxByte
);
	logic busy_r, busy_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [3:0] bitIdx_r, bitIdx_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic valid_r, valid_nxt;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		busy_nxt = busy_r;
		cnt_nxt = cnt_r;
		bitIdx_nxt = bitIdx_r;
		shift_nxt = shift_r;
		valid_nxt = 1'b0;
		if (!busy_r) begin
			if (!rxLine) begin
				// Land in mid start bit
				busy_nxt = 1'b1;
				cnt_nxt = {1'b0, bitDiv[15:1]};
				bitIdx_nxt = 4'h0;
			end
		end else if (cnt_r != 16'h0000) begin
			cnt_nxt = cnt_r - 16'h0001;
		end else begin
			cnt_nxt = bitDiv - 16'h0001;
			bitIdx_nxt = bitIdx_r + 4'h1;
			if (bitIdx_r == 4'h0) begin
				// Glitch, not a start bit
				if (rxLine)
					busy_nxt = 1'b0;
			end else if (bitIdx_r <= 4'(SDM_DATA_BITS)) begin
				shift_nxt = {rxLine, shift_r[7:1]};
			end else begin
				// Stop bit; framing error drops the byte
				busy_nxt = 1'b0;
				valid_nxt = rxLine;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			busy_r <= 1'b0;
			cnt_r <= 16'h0000;
			bitIdx_r <= 4'h0;
			shift_r <= 8'h00;
			valid_r <= 1'b0;
		end else if (clkEn) begin
			busy_r <= busy_nxt;
			cnt_r <= cnt_nxt;
			bitIdx_r <= bitIdx_nxt;
			shift_r <= shift_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign rxValid = valid_r;
	assign rxByte = shift_r;
endmodule : sdm_uart_rx

// File: hdl/sdm_uart_tx.sv
// Serial byte transmitter, 8N1, bit period set by a divisor input.
// Assumes txGo is only raised while txBusy is low.
module sdm_uart_tx
	import sdm_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clkEn,
	// Timing
	input wire logic [15:0] bitDiv,
	// Byte to send
	input wire logic txGo,
	input wire logic [7:0] txByte,
	output logic txBusy,
	output logic txDone,
	// Line
	output logic txLine
);
	logic busy_r, busy_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [3:0] bitIdx_r, bitIdx_nxt;
	logic [9:0] frame_r, frame_nxt;
	logic line_r, line_nxt;
	logic done_r, done_nxt;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		busy_nxt = busy_r;
		cnt_nxt = cnt_r;
		bitIdx_nxt = bitIdx_r;
		frame_nxt = frame_r;
		line_nxt = line_r;
		done_nxt = 1'b0;
		if (!busy_r) begin
			line_nxt = 1'b1;
			if (txGo) begin
				// Stop, data LSB first, start
				frame_nxt = {1'b1, txByte, 1'b0};
				busy_nxt = 1'b1;
				cnt_nxt = bitDiv - 16'h0001;
				bitIdx_nxt = 4'h0;
				line_nxt = 1'b0;
			end
		end else if (cnt_r != 16'h0000) begin
			cnt_nxt = cnt_r - 16'h0001;
		end else if (bitIdx_r == 4'(SDM_DATA_BITS + 1)) begin
			busy_nxt = 1'b0;
			done_nxt = 1'b1;
		end else begin
			cnt_nxt = bitDiv - 16'h0001;
			bitIdx_nxt = bitIdx_r + 4'h1;
			line_nxt = frame_r[bitIdx_r + 4'h1];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			busy_r <= 1'b0;
			cnt_r <= 16'h0000;
			bitIdx_r <= 4'h0;
			frame_r <= 10'h3FF;
			line_r <= 1'b1;
			done_r <= 1'b0;
		end else if (clkEn) begin
			busy_r <= busy_nxt;
			cnt_r <= cnt_nxt;
			bitIdx_r <= bitIdx_nxt;
			frame_r <= frame_nxt;
			line_r <= line_nxt;
			done_r <= done_nxt;
		end
	end

	assign txBusy = busy_r;
	assign txDone = done_r;
	assign txLine = line_r;
endmodule : sdm_uart_tx

// File: tb/sdm_monitor_sva.sv
// Checker for the serial debug monitor, bound to its top module.
// Assumes the baud strap is static; checks pause while clkEn freezes the block.
module sdm_monitor_chk
	import sdm_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clkEn,
	// Straps and serial pair
	input wire logic modeStrapA,
	input wire logic modeStrapB,
	input wire logic baudSelectStrap,
	input wire logic serialReceivePin,
	input wire logic serialTransmitPin,
	// Observed outputs
	input wire logic monitorBoot,
	input wire logic serialPinsSelected,
	input wire logic [63:0] portPullDown,
	input wire sdm_mem_req_t memReq,
	input wire sdm_mem_rsp_t memRsp,
	input wire sdm_exec_t execCtl
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst || !clkEn);
	////////////////////////////////////////
	// Run length of the line level, so bit widths can be judged
	logic prevTx_r;
	logic [15:0] runLen_r;
	logic [15:0] bitDiv;
	assign bitDiv = baudSelectStrap ? SDM_DIV_FAST : SDM_DIV_STD;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			prevTx_r <= 1'b1;
			runLen_r <= 16'h0000;
		end else if (clkEn) begin
			prevTx_r <= serialTransmitPin;
			// Saturates so a long idle gap cannot wrap below one bit
			if (serialTransmitPin != prevTx_r)
				runLen_r <= 16'h0001;
			else if (runLen_r != 16'hFFFF)
				runLen_r <= runLen_r + 16'h0001;
		end
	end
	////////////////////////////////////////
	property p_boot;
		$fell(srst) |-> monitorBoot == ($past(modeStrapA) && !$past(modeStrapB));
	endproperty
	a_boot: assert property (p_boot) else $error("boot select differs from straps");
	property p_pull;
		portPullDown == (monitorBoot ? SDM_PULL_DOWN_MASK : {64{1'b1}}) && serialPinsSelected == monitorBoot;
	endproperty
	a_pull: assert property (p_pull) else $error("port pulls or serial select wrong");
	property p_quiet;
		!monitorBoot |-> serialTransmitPin && !memReq.valid && !execCtl.jump;
	endproperty
	a_quiet: assert property (p_quiet) else $error("activity outside debug mode");
	property p_hold;
		memReq.valid && !memRsp.ack |=> memReq.valid && $stable(memReq.addr) && $stable(memReq.wdata);
	endproperty
	a_hold: assert property (p_hold) else $error("request changed before ack");
	property p_drop;
		memReq.valid && memRsp.ack |=> !memReq.valid;
	endproperty
	a_drop: assert property (p_drop) else $error("request kept after ack");
	property p_wrquiet;
		memReq.valid && memReq.write |-> serialTransmitPin;
	endproperty
	a_wrquiet: assert property (p_wrquiet) else $error("answer sent before write done");
	property p_flash;
		memReq.valid |-> memReq.flash == (memReq.write && memReq.space == SDM_SP_MEM && memReq.addr >= SDM_FLASH_LO
			&& memReq.addr <= SDM_FLASH_HI);
	endproperty
	a_flash: assert property (p_flash) else $error("flash flag wrong");
	property p_silent;
		execCtl.jump || execCtl.resume |=> (!execCtl.jump && !execCtl.resume && serialTransmitPin) [*8];
	endproperty
	a_silent: assert property (p_silent) else $error("jump or resume not a silent pulse");
	property p_excl;
		!(execCtl.jump && execCtl.resume);
	endproperty
	a_excl: assert property (p_excl) else $error("jump and resume together");
	property p_bitlen;
		$rose(serialTransmitPin) |-> runLen_r % bitDiv == 16'h0000;
	endproperty
	a_bitlen: assert property (p_bitlen) else $error("low run not whole bits");
	property p_frame;
		$rose(serialTransmitPin) |-> runLen_r <= bitDiv * 16'h0009;
	endproperty
	a_frame: assert property (p_frame) else $error("low run longer than start and data");
	property p_stop;
		$fell(serialTransmitPin) |-> runLen_r >= bitDiv;
	endproperty
	a_stop: assert property (p_stop) else $error("stop or idle shorter than a bit");
endmodule : sdm_monitor_chk

bind sdm_monitor sdm_monitor_chk chk_u (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn),
	.modeStrapA(modeStrapA), .modeStrapB(modeStrapB), .baudSelectStrap(baudSelectStrap),
	.serialReceivePin(serialReceivePin), .serialTransmitPin(serialTransmitPin), .monitorBoot(monitorBoot),
	.serialPinsSelected(serialPinsSelected), .portPullDown(portPullDown), .memReq(memReq),
	.memRsp(memRsp), .execCtl(execCtl));

// File: tb/sdm_host_model.sv
// Debugger host on the serial pair: sends command bytes, receives answers.
// Assumes the bench clock and a bit divisor that matches the baud strap.
module sdm_host_model
	import sdm_pkg::*;
#(
	parameter logic [15:0] BIT_DIV = SDM_DIV_FAST
)
(
	// Clock
	input wire logic ref_clk,
	// Serial pair, host view
	output logic hostTx,
	input wire logic hostRx
);
	timeunit 1ns;
	timeprecision 1ps;
	int lowCnt;
	initial begin
		hostTx = 1'b1;
	end
	// Low run seen so far; an answer may start inside our own stop bit
	always @(negedge ref_clk) begin
		lowCnt <= (hostRx === 1'b0) ? lowCnt + 1 : 0;
	end
	////////////////////////////////////////
	// Only this pin pair carries the protocol
	task automatic send_byte(input logic [7:0] data);
		logic [9:0] frame;
		frame = {1'b1, data, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge ref_clk);
			hostTx = frame[i];
			repeat (BIT_DIV - 1) @(negedge ref_clk);
		end
	endtask : send_byte
	// Returns after the stop bit, or after limit cycles with no start bit, so the next command waits for it
	task automatic recv_byte(input int limit, output logic [7:0] data, output logic framed);
		int waitCnt;
		int skip;
		logic startLow;
		waitCnt = 0;
		data = 8'h00;
		framed = 1'b0;
		while (hostRx !== 1'b0 && waitCnt < limit) begin
			@(negedge ref_clk);
			waitCnt++;
		end
		if (hostRx === 1'b0) begin
			// Land in mid start bit, counting what already went by
			skip = int'(BIT_DIV / 2) - lowCnt;
			repeat ((skip > 0) ? skip : 0) @(negedge ref_clk);
			startLow = (hostRx === 1'b0);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_DIV) @(negedge ref_clk);
				data[i] = hostRx;
			end
			repeat (BIT_DIV) @(negedge ref_clk);
			framed = startLow && (hostRx === 1'b1);
			repeat (BIT_DIV / 2) @(negedge ref_clk);
		end
	endtask : recv_byte
endmodule : sdm_host_model

// File: tb/testbench.sv
// Self-checking bench for the serial debug monitor at the fast baud rate.
// Assumes the checker and host model files are compiled before it.
module testbench
	import sdm_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	// Slow rate would not fit the cycle budget
	localparam int LIMIT = 105000;
	typedef struct {logic [7:0] cmd [4]; int nIn; int nOut; logic [7:0] ans [2]; int nReq; logic wr;} sdm_row_t;
	logic ref_clk;
	logic srst;
	logic modeStrapA;
	logic modeStrapB;
	logic serialReceivePin;
	logic serialTransmitPin;
	logic monitorBoot;
	logic serialPinsSelected;
	logic [63:0] portPullDown;
	sdm_mem_req_t memReq;
	sdm_mem_rsp_t memRsp;
	sdm_exec_t execCtl;
	sdm_mem_req_t reqSeen;
	int ackWait;
	int jumpCnt;
	logic [15:0] jumpAddr;
	int failures;
	int compares;
	int cycles;
	sdm_row_t rows [4];
	logic [7:0] got;
	logic framed;
	////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	sdm_monitor dut_u (.ref_clk(ref_clk), .srst(srst), .clkEn(1'b1), .modeStrapA(modeStrapA),
		.modeStrapB(modeStrapB), .baudSelectStrap(1'b1), .serialReceivePin(serialReceivePin),
		.serialTransmitPin(serialTransmitPin), .monitorBoot(monitorBoot), .serialPinsSelected(serialPinsSelected),
		.portPullDown(portPullDown), .memReq(memReq), .memRsp(memRsp), .execCtl(execCtl));
	sdm_host_model #(.BIT_DIV(SDM_DIV_FAST)) host_u (.ref_clk(ref_clk), .hostTx(serialReceivePin),
		.hostRx(serialTransmitPin));
	// Processor side: ack each request three cycles late
	always @(negedge ref_clk) begin
		if (memReq.valid === 1'b1 && memRsp.ack !== 1'b1 && ackWait == 2) begin
			memRsp.ack <= 1'b1;
			memRsp.rdata <= {16'h7E81, memReq.addr[7:0], 8'hC5};
			reqSeen <= memReq;
			ackWait <= 0;
		end else begin
			memRsp.ack <= 1'b0;
			if (memReq.valid === 1'b1 && memRsp.ack !== 1'b1)
				ackWait <= ackWait + 1;
		end
		if (execCtl.jump === 1'b1) begin
			jumpCnt <= jumpCnt + 1;
			jumpAddr <= execCtl.addr;
		end
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			failures++;
			complete_run();
		end
	end
	////////////////////////////////////////
	task automatic check_val(input string name, input logic [63:0] exp, input logic [63:0] seen);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check_val
	task automatic do_reset(input logic strapA, input logic strapB);
		@(negedge ref_clk);
		srst = 1'b1;
		modeStrapA = strapA;
		modeStrapB = strapB;
		repeat (8) @(negedge ref_clk);
		srst = 1'b0;
		@(negedge ref_clk);
	endtask : do_reset
	task automatic complete_run();
		$display("Compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	////////////////////////////////////////
	initial begin
		srst = 1'b1;
		modeStrapA = 1'b1;
		modeStrapB = 1'b0;
		memRsp = '0;
		reqSeen = '0;
		ackWait = 0;
		jumpCnt = 0;
		jumpAddr = 16'h0000;
		failures = 0;
		compares = 0;
		cycles = 0;
		rows[0] = '{'{SDM_CMD_LINK_INIT, 8'h00, 8'h00, 8'h00}, 1, 1, '{SDM_ACK_BYTE, 8'h00}, 0, 1'b0};
		rows[1] = '{'{SDM_CMD_PROCESSOR_INTERNAL_RAM_WR, 8'h5A, 8'h21, 8'h43}, 4, 1, '{SDM_ACK_BYTE, 8'h00}, 1, 1'b1};
		rows[2] = '{'{SDM_CMD_PROCESSOR_INTERNAL_RAM_RD, 8'h5A, 8'h00, 8'h00}, 2, 2, '{8'hC5, 8'h5A}, 1, 1'b0};
		rows[3] = '{'{SDM_CMD_JUMP, 8'h34, 8'h12, 8'h00}, 3, 0, '{8'h00, 8'h00}, 0, 1'b0};
		do_reset(1'b1, 1'b0);
		check_val("boot", 64'h1, 64'(monitorBoot));
		check_val("pulls", SDM_PULL_DOWN_MASK, portPullDown);
		check_val("serial on", 64'h1, 64'(serialPinsSelected));
		for (int r = 0; r < 4; r++) begin
			for (int i = 0; i < rows[r].nIn; i++) begin
				host_u.send_byte(rows[r].cmd[i]);
			end
			for (int i = 0; i < 2; i++) begin
				host_u.recv_byte(400, got, framed);
				check_val("answer present", 64'(i < rows[r].nOut), 64'(framed));
				if (i < rows[r].nOut) check_val("answer byte", 64'(rows[r].ans[i]), 64'(got));
			end
			if (rows[r].nReq > 0) begin
				check_val("req space", 64'(SDM_SP_PROCESSOR_INTERNAL_RAM), 64'(reqSeen.space));
				check_val("req addr", 64'h5A, 64'(reqSeen.addr));
				check_val("req write", 64'(rows[r].wr), 64'(reqSeen.write));
				check_val("req flash", 64'h0, 64'(reqSeen.flash));
				if (rows[r].wr) check_val("req data", 64'h4321, 64'(reqSeen.wdata));
			end
		end
		check_val("jumps", 64'h1, 64'(jumpCnt));
		check_val("jump addr", 64'h1234, 64'(jumpAddr));
		do_reset(1'b0, 1'b0);
		check_val("boot off", 64'h0, 64'(monitorBoot));
		check_val("pulls off", {64{1'b1}}, portPullDown);
		check_val("serial off", 64'h0, 64'(serialPinsSelected));
		complete_run();
	end
endmodule : testbench
